//--- hdl/mcdma_regs.svh
`ifndef MCDMA_REGS_SVH
`define MCDMA_REGS_SVH

`define MCDMA_CH 3
`define MCDMA_AW 16
`define MCDMA_CW 16
`define MCDMA_DW 16

`define MCDMA_STEP_DEC 2'h2
`define MCDMA_STEP_INC 2'h3

`define MCDMA_MODE_REPEAT 2
`define MCDMA_MODE_BURST 1
`define MCDMA_MODE_KIND_SINGLE 2'h0

`define MCDMA_BURST_ITEMS 3'h4
`define MCDMA_BURST_GAP 2'h2

`define MCDMA_ADDR_STEP_BYTE 16'h0001
`define MCDMA_ADDR_STEP_WORD 16'h0002

`endif

//--- hdl/mcdma_pkg.sv
`include "mcdma_regs.svh"
package mcdma_pkg;

    typedef struct packed {
        logic [2:0] mode;
        logic [1:0] src_step;
        logic [1:0] dst_step;
        logic src_byte;
        logic dst_byte;
        logic level;
        logic [`MCDMA_AW-1:0] src;
        logic [`MCDMA_AW-1:0] dst;
        logic [`MCDMA_CW-1:0] size;
    } mcdma_cfg_type;

    typedef struct packed {
        logic en;
        logic run;
        logic pend;
        logic armed;
        logic done;
        logic trig_d;
        logic [`MCDMA_CW-1:0] cnt;
        logic [`MCDMA_CW-1:0] save;
        logic [`MCDMA_AW-1:0] wsrc;
        logic [`MCDMA_AW-1:0] wdst;
    } mcdma_chan_type;

    typedef struct packed {
        logic [`MCDMA_AW-1:0] addr;
        logic dbyte;
        logic [`MCDMA_DW-1:0] data;
    } mcdma_entry_type;

    typedef enum logic [0:0] {
        MCDMA_RUN = 1'b0,
        MCDMA_GAP = 1'b1
    } mcdma_eng_type;

    typedef struct packed {
        mcdma_chan_type [`MCDMA_CH-1:0] ch;
        mcdma_entry_type [1:0] buffer;
        logic wp;
        logic rp;
        logic [1:0] fill;
        mcdma_eng_type eng;
        logic [2:0] burst_n;
        logic [1:0] gap_n;
    } mcdma_state_type;

endpackage

//--- hdl/mcdma_engine.sv
`timescale 1ns/1ps
`include "mcdma_regs.svh"
module mcdma_engine (
    input wire logic clk,
    input wire logic rst_n,
    input mcdma_pkg::mcdma_cfg_type [`MCDMA_CH-1:0] cfg,
    input wire logic [`MCDMA_CH-1:0] cfg_load,
    input wire logic [`MCDMA_CH-1:0] enable_set,
    input wire logic [`MCDMA_CH-1:0] enable_clr,
    input wire logic [`MCDMA_CH-1:0] done_clr,
    input wire logic [`MCDMA_CH-1:0] trig,
    output logic [`MCDMA_CH-1:0] chan_enable,
    output logic [`MCDMA_CH-1:0] chan_done_flag,
    output logic [`MCDMA_CH-1:0][`MCDMA_CW-1:0] transfer_count,
    output logic rd_en,
    output logic [`MCDMA_AW-1:0] rd_addr,
    output logic rd_byte,
    input wire logic [`MCDMA_DW-1:0] rd_data,
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [`MCDMA_AW-1:0] wr_addr,
    output logic wr_byte,
    output logic [`MCDMA_DW-1:0] wr_data,
    output logic cpu_stall
);
    import mcdma_pkg::*;

    mcdma_state_type q;
    mcdma_state_type d;
    logic [`MCDMA_CH-1:0] go;
    logic [1:0] sel;
    logic found;
    logic issue;
    logic push;
    logic pop;
    logic run_any;
    logic [`MCDMA_AW-1:0] src_now;
    logic [`MCDMA_AW-1:0] dst_now;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [`MCDMA_AW-1:0] step_addr(
        input logic [`MCDMA_AW-1:0] a,
        input logic [1:0] how,
        input logic is_byte
    );
        logic [`MCDMA_AW-1:0] inc;
        inc = is_byte ? `MCDMA_ADDR_STEP_BYTE : `MCDMA_ADDR_STEP_WORD;
        case (how)
            `MCDMA_STEP_DEC: step_addr = a - inc;
            `MCDMA_STEP_INC: step_addr = a + inc;
            default: step_addr = a;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        d = q;
        go = '0;
        sel = 2'h0;
        found = 1'b0;
        issue = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        run_any = 1'b0;
        src_now = '0;
        dst_now = '0;
        rd_en = 1'b0;
        rd_addr = '0;
        rd_byte = 1'b0;

        // software side effects first
        for (int i = 0; i < `MCDMA_CH; i++) begin
            d.ch[i].trig_d = trig[i];
            if (done_clr[i]) begin
                d.ch[i].done = 1'b0;
            end
            if (enable_set[i]) begin
                d.ch[i].en = 1'b1;
            end
            if (enable_clr[i]) begin
                d.ch[i].en = 1'b0;
                d.ch[i].run = 1'b0;
                d.ch[i].pend = 1'b0;
            end
            if (cfg_load[i]) begin
                d.ch[i].cnt = cfg[i].size;
                d.ch[i].save = cfg[i].size;
                d.ch[i].armed = 1'b0;
                d.ch[i].run = 1'b0;
                d.ch[i].pend = 1'b0;
            end
            // rising edge, ignored while a block or burst runs
            if (!cfg[i].level && trig[i] && !q.ch[i].trig_d && d.ch[i].en
                && !d.ch[i].run) begin
                d.ch[i].pend = 1'b1;
            end
            if (d.ch[i].en && d.ch[i].cnt == '0) begin
                d.ch[i].pend = 1'b0;
            end
            if (cfg[i].level) begin
                go[i] = d.ch[i].en && d.ch[i].cnt != '0 && trig[i];
            end else begin
                go[i] = d.ch[i].en && d.ch[i].cnt != '0
                    && (d.ch[i].run || d.ch[i].pend);
            end
            if (d.ch[i].run && cfg[i].mode[`MCDMA_MODE_BURST] == 1'b0) begin
                run_any = 1'b1;
            end
        end

        // lowest channel number wins
        for (int i = `MCDMA_CH - 1; i >= 0; i--) begin
            if (go[i]) begin
                sel = 2'(i);
                found = 1'b1;
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // read half of an item; the write half drains from the buffer
        issue = found && q.fill != 2'h2 && q.eng == MCDMA_RUN;
        if (issue) begin
            push = 1'b1;
            if (d.ch[sel].armed) begin
                src_now = d.ch[sel].wsrc;
                dst_now = d.ch[sel].wdst;
            end else begin
                src_now = cfg[sel].src;
                dst_now = cfg[sel].dst;
                d.ch[sel].save = d.ch[sel].cnt;
            end
            rd_en = 1'b1;
            rd_addr = src_now;
            rd_byte = cfg[sel].src_byte;
            d.buffer[q.wp].addr = dst_now;
            d.buffer[q.wp].dbyte = cfg[sel].dst_byte;
            if (cfg[sel].src_byte || cfg[sel].dst_byte) begin
                d.buffer[q.wp].data = {8'h00, rd_data[7:0]};
            end else begin
                d.buffer[q.wp].data = rd_data;
            end
            d.wp = ~q.wp;
            d.ch[sel].wsrc = step_addr(src_now, cfg[sel].src_step,
                cfg[sel].src_byte);
            d.ch[sel].wdst = step_addr(dst_now, cfg[sel].dst_step,
                cfg[sel].dst_byte);
            d.ch[sel].armed = 1'b1;
            d.ch[sel].pend = 1'b0;
            d.ch[sel].cnt = d.ch[sel].cnt - `MCDMA_CW'(1);
            d.ch[sel].run = cfg[sel].mode[1:0] != `MCDMA_MODE_KIND_SINGLE;
            if (d.ch[sel].cnt == '0) begin
                d.ch[sel].cnt = d.ch[sel].save;
                d.ch[sel].done = 1'b1;
                d.ch[sel].armed = 1'b0;
                d.ch[sel].run = 1'b0;
                if (!cfg[sel].mode[`MCDMA_MODE_REPEAT]) begin
                    d.ch[sel].en = 1'b0;
                end
            end
            // burst pacing
            if (cfg[sel].mode[`MCDMA_MODE_BURST]) begin
                d.burst_n = q.burst_n + 3'h1;
                if (!d.ch[sel].run) begin
                    d.burst_n = 3'h0;
                end else if (d.burst_n == `MCDMA_BURST_ITEMS) begin
                    d.burst_n = 3'h0;
                    d.eng = MCDMA_GAP;
                    d.gap_n = 2'h0;
                end
            end
        end

        case (q.eng)
            MCDMA_RUN: begin
            end
            MCDMA_GAP: begin
                d.gap_n = q.gap_n + 2'h1;
                if (d.gap_n == `MCDMA_BURST_GAP) begin
                    d.eng = MCDMA_RUN;
                end
            end
            default: begin
                d.eng = MCDMA_RUN;
            end
        endcase

        ////////////////////////////////////////////////////////////////////////
        pop = q.fill != 2'h0 && wr_ready;
        if (pop) begin
            d.rp = ~q.rp;
        end
        d.fill = 2'(q.fill + {1'b0, push} - {1'b0, pop});
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        for (int i = 0; i < `MCDMA_CH; i++) begin
            chan_enable[i] = q.ch[i].en;
            chan_done_flag[i] = q.ch[i].done;
            transfer_count[i] = q.ch[i].cnt;
        end
    end

    assign wr_valid = q.fill != 2'h0;
    assign wr_addr = q.buffer[q.rp].addr;
    assign wr_byte = q.buffer[q.rp].dbyte;
    assign wr_data = q.buffer[q.rp].data;
    // processor held during block items, released in burst gaps
    assign cpu_stall = q.eng == MCDMA_RUN && (issue || wr_valid || run_any);

endmodule

//--- test/mcdma_checker.sv
`timescale 1ns/1ps
module mcdma_checker (
    input wire logic clk,
    input wire logic rst_n,
    input mcdma_pkg::mcdma_cfg_type [2:0] cfg,
    input wire logic [2:0] cfg_load,
    input wire logic [2:0] enable_clr,
    input wire logic [2:0] chan_enable,
    input wire logic [2:0] chan_done_flag,
    input wire logic [2:0][15:0] transfer_count,
    input wire logic rd_en,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic [15:0] wr_addr,
    input wire logic wr_byte,
    input wire logic [15:0] wr_data,
    input wire logic cpu_stall
);
    import mcdma_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_stall_on_read: assert property (rd_en |-> cpu_stall)
        else $error("stall low during read");
    a_read_fills_buf: assert property (rd_en |=> wr_valid)
        else $error("read not followed by write");
    a_write_holds: assert property (wr_valid && !wr_ready |=>
        wr_valid && $stable({wr_addr, wr_byte, wr_data}))
        else $error("write changed while stalled");
    a_byte_upper_zero: assert property (wr_valid && wr_byte |-> wr_data[15:8] == 8'h00)
        else $error("byte write upper not zero");
    a_read_needs_en: assert property (rd_en |-> chan_enable != 3'h0)
        else $error("read with no channel enabled");
    a_count_on_read: assert property ($changed(transfer_count[0]) && $past(rst_n)
        && !$past(cfg_load[0]) |-> $past(rd_en))
        else $error("count moved without read");
    a_done_at_last: assert property ($rose(chan_done_flag[0]) && $past(rst_n) |->
        $past(rd_en) && $past(transfer_count[0]) == 16'h0001)
        else $error("done set early");
    a_repeat_keeps_en: assert property (chan_enable[1] && cfg[1].mode[2] && !enable_clr[1]
        |=> chan_enable[1])
        else $error("repeat mode lost enable");
endmodule
bind mcdma_engine mcdma_checker u_mcdma_checker (.*);

//--- test/mcdma_mem.sv
`timescale 1ns/1ps
module mcdma_mem (
    input wire logic clk,
    input wire logic stall,
    input wire logic rd_en,
    input wire logic [15:0] rd_addr,
    input wire logic rd_byte,
    output logic [15:0] rd_data,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [15:0] wr_addr,
    input wire logic wr_byte,
    input wire logic [15:0] wr_data
);
    logic [7:0] mem [0:255];
    logic [15:0] junk = 16'h0000;
    wire logic [7:0] a = rd_addr[7:0];
    assign wr_ready = !stall;
    // idle bus shows a moving pattern, byte reads a poisoned upper half
    always_comb begin
        if (!rd_en) rd_data = junk;
        else if (rd_byte) rd_data = {~mem[a], mem[a]};
        else rd_data = {mem[a + 8'h01], mem[a]};
    end
    always @(posedge clk) begin
        junk <= junk + 16'h5A5B;
        if (wr_valid && wr_ready) begin
            mem[wr_addr[7:0]] <= wr_data[7:0];
            if (!wr_byte) mem[wr_addr[7:0] + 8'h01] <= wr_data[15:8];
        end
    end
endmodule

//--- test/mcdma_engine_tb.sv
`timescale 1ns/1ps
module mcdma_engine_tb;
    import mcdma_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic stall = 1'b0;
    mcdma_cfg_type [2:0] cfg = '0;
    logic [2:0] cfg_load = 3'h0, enable_set = 3'h0, enable_clr = 3'h0;
    logic [2:0] done_clr = 3'h0, trig = 3'h0, chan_enable, chan_done_flag;
    logic [2:0][15:0] transfer_count;
    logic rd_en, rd_byte, wr_valid, wr_ready, wr_byte, cpu_stall;
    logic [15:0] rd_addr, rd_data, wr_addr, wr_data;
    int err_total = 0, cmp_count = 0, nrd = 0, first = 0, last = 0, cyc = 0;
    mcdma_engine u_mcdma_engine (.*);
    mcdma_mem u_mcdma_mem (.*);
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (rd_en) begin
            if (nrd == 0) first = cyc;
            last = cyc;
            nrd++;
        end
    end
    function automatic logic [15:0] m(int a);
        return {8'h00, u_mcdma_mem.mem[a]};
    endfunction
    function automatic logic [15:0] w(int a);
        return {u_mcdma_mem.mem[a + 1], u_mcdma_mem.mem[a]};
    endfunction
    function automatic logic [15:0] e(int a);
        return {8'h00, 8'(a * 3 + 1)};
    endfunction
    task tick(int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task chk(logic [15:0] got, logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task go(logic [2:0] l, logic [2:0] s, logic [2:0] t);
        cfg_load = l;
        enable_set = s;
        trig = t;
        tick(1);
        {cfg_load, enable_set, trig} = 9'h000;
        tick(1);
    endtask
    task setup(int c, logic [2:0] md, logic [1:0] ss, logic [1:0] ds, logic sb, logic db,
               logic [15:0] s, logic [15:0] d, logic [15:0] n);
        cfg[c] = '{md, ss, ds, sb, db, 1'b0, s, d, n};
        done_clr = 3'(1 << c);
        go(3'(1 << c), 3'h0, 3'h0);
        done_clr = 3'h0;
        go(3'h0, 3'(1 << c), 3'h0);
        nrd = 0;
    endtask
    task idle;
        int q;
        q = 0;
        for (int i = 0; i < 300 && q < 3; i++) begin
            tick(1);
            q = (cpu_stall || wr_valid || rd_en) ? 0 : q + 1;
        end
    endtask
    task finish_test;
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 256; i++) u_mcdma_mem.mem[i] = 8'(i * 3 + 1);
        tick(6);
        rst_n = 1'b1;
        tick(1);
        setup(0, 3'h1, 2'h3, 2'h3, 1'b0, 1'b0, 16'h0010, 16'h0080, 16'h0004);
        stall = 1'b1;
        go(3'h0, 3'h0, 3'h1);
        tick(6);
        chk(transfer_count[0], 16'h0002);
        go(3'h0, 3'h0, 3'h1);
        stall = 1'b0;
        idle();
        for (int i = 0; i < 8; i++) chk(m(8'h80 + i), e(8'h10 + i));
        chk(16'(nrd), 16'h0004);
        chk(transfer_count[0], 16'h0004);
        chk({chan_enable[0], chan_done_flag[0]}, 16'h0001);
        setup(1, 3'h4, 2'h0, 2'h3, 1'b0, 1'b1, 16'h0020, 16'h00A0, 16'h0002);
        for (int k = 0; k < 3; k++) begin
            go(3'h0, 3'h0, 3'h2);
            idle();
            if (k == 0) chk(transfer_count[1], 16'h0001);
        end
        for (int i = 0; i < 2; i++) chk(m(8'hA0 + i), e(8'h20));
        chk(m(8'hA2), e(8'hA2));
        chk(m(8'hA3), e(8'hA3));
        chk({chan_enable[1], chan_done_flag[1]}, 16'h0003);
        setup(2, 3'h0, 2'h2, 2'h2, 1'b1, 1'b0, 16'h0031, 16'h00C4, 16'h0002);
        for (int k = 0; k < 2; k++) begin
            go(3'h0, 3'h0, 3'h4);
            idle();
        end
        chk(w(8'hC4), e(8'h31));
        chk(w(8'hC2), e(8'h30));
        chk({chan_enable[2], 15'(nrd)}, 16'h0002);
        setup(0, 3'h1, 2'h3, 2'h3, 1'b0, 1'b0, 16'h0010, 16'h0090, 16'h0000);
        go(3'h0, 3'h0, 3'h1);
        idle();
        chk(16'(nrd), 16'h0000);
        setup(0, 3'h2, 2'h3, 2'h3, 1'b0, 1'b0, 16'h0040, 16'h00E0, 16'h0008);
        go(3'h0, 3'h0, 3'h1);
        idle();
        chk(16'(nrd), 16'h0008);
        chk(16'(last - first + 1), 16'h000A);
        chk({chan_enable[0], chan_done_flag[0]}, 16'h0001);
        for (int i = 0; i < 16; i++) chk(m(8'hE0 + i), e(8'h40 + i));
        finish_test();
    end
    initial begin
        #200000;
        err_total++;
        finish_test();
    end
endmodule
